// [rtl/cac_defs.svh]
// Register offsets, field positions, reset values and fixed indices of the core datapath
`ifndef CAC_DEFS_SVH
`define CAC_DEFS_SVH

`define CAC_OFF_CTRL   7'h00
`define CAC_OFF_TPAG   7'h04
`define CAC_OFF_VPAG   7'h08
`define CAC_OFF_HOLD   7'h0c
`define CAC_OFF_STAT   7'h10
`define CAC_WREG_BIT   6

`define CAC_BIT_IPLX   3
`define CAC_BIT_VIEW   2

`define CAC_BIT_C      0
`define CAC_BIT_Z      1
`define CAC_BIT_OV     2
`define CAC_BIT_N      3
`define CAC_BIT_IPL    5
`define CAC_BIT_DC     8
`define CAC_STAT_WMASK 16'h01ef

`define CAC_RST_CTRL   16'h0000
`define CAC_RST_STAT   16'h0000
`define CAC_RST_PAGE   8'h00
`define CAC_RST_HOLD   14'h0000
`define CAC_RST_WREG   16'h0000

`define CAC_LEG_LO     4'h2
`define CAC_LEG_HI     4'h3
`define CAC_TOP_PAIR   3'h7
`define CAC_Q_REG      4'h0
`define CAC_R_REG      4'h1

`endif

// [rtl/cac_pkg.sv]
// Types shared by the core datapath and its users
package cac_pkg;

    typedef enum logic [1:0] {
        CAC_K_NONE = 2'b00,
        CAC_K_ALU  = 2'b01,
        CAC_K_MUL  = 2'b10,
        CAC_K_DIV  = 2'b11
    } cac_kind_t;

    typedef enum logic [3:0] {
        CAC_ADD  = 4'b0000,
        CAC_ADDC = 4'b0001,
        CAC_SUB  = 4'b0010,
        CAC_SUBB = 4'b0011,
        CAC_AND  = 4'b0100,
        CAC_IOR  = 4'b0101,
        CAC_XOR  = 4'b0110,
        CAC_SL   = 4'b0111,
        CAC_LSR  = 4'b1000,
        CAC_ASR  = 4'b1001
    } cac_alu_op_t;

    typedef enum logic [2:0] {
        CAC_M_SS   = 3'b000,
        CAC_M_UU   = 3'b001,
        CAC_M_SLIT = 3'b010,
        CAC_M_ULIT = 3'b011,
        CAC_M_US   = 3'b100,
        CAC_M_BYTE = 3'b101,
        CAC_M_LEG  = 3'b110
    } cac_mul_mode_t;

endpackage

// [rtl/cac_core.sv]
// Core datapath: ALU, multiplier, divider, working registers and core control over Wishbone
`timescale 1ns/1ps
`include "cac_defs.svh"

module cac_core (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [6:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  exec_valid_i,
    input  wire cac_pkg::cac_kind_t    exec_kind_i,
    input  wire cac_pkg::cac_alu_op_t  alu_op_i,
    input  wire cac_pkg::cac_mul_mode_t mul_mode_i,
    input  wire logic                  byte_mode_i,
    input  wire logic                  src_mem_i,
    input  wire logic                  dest_mem_i,
    input  wire logic                  div_signed_i,
    input  wire logic                  div_long_i,
    input  wire logic [3:0]            wa_i,
    input  wire logic [3:0]            wb_i,
    input  wire logic [3:0]            wd_i,
    input  wire logic [4:0]            lit5_i,
    input  wire logic [12:0]           legacy_addr_i,
    input  wire logic [15:0]           mem_data_i,
    output logic      [15:0]           mem_rd_addr_o,
    output logic      [15:0]           mem_wdata_o,
    output logic                       mem_we_o,
    output logic                       mem_byte_o,
    output logic                       exec_fault_o,
    input  wire logic                  ipl_ext_set_i,
    input  wire logic                  hold_start_i,
    input  wire logic [13:0]           hold_count_i,
    output logic      [3:0]            ipl_o,
    output logic                       user_irq_block_o,
    output logic                       low_irq_hold_o,
    input  wire logic [15:0]           tbl_ea_i,
    output logic      [23:0]           tbl_addr_o,
    input  wire logic [15:0]           data_addr_i,
    output logic                       view_hit_o,
    output logic      [22:0]           view_addr_o,
    output logic      [15:0]           status_o
);
    import cac_pkg::*;

    logic [15:0] wreg_q [16];
    logic        iplx_q;
    logic        view_q;
    logic [7:0]  tpag_q;
    logic [7:0]  vpag_q;
    logic [13:0] hold_q;
    logic [15:0] stat_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [15:0] mem_wdata_q;
    logic        mem_we_q;
    logic        mem_byte_q;
    logic        fault_q;

    logic        bus_req;
    logic        bus_wr;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [15:0] bx;
    logic [16:0] sum;
    logic        is_sub;
    logic        cin;
    logic [15:0] alu_res;
    logic [15:0] alu_stat;
    logic        alu_upd;
    logic [16:0] mul_a;
    logic [16:0] mul_b;
    logic signed [33:0] prod;
    logic [31:0] mul_res;
    logic [31:0] dvd;
    logic [31:0] dvs;
    logic [31:0] quo;
    logic [31:0] rem;
    logic        wr0_en;
    logic [3:0]  wr0_idx;
    logic [15:0] wr0_val;
    logic        wr0_byte;
    logic        wr1_en;
    logic [3:0]  wr1_idx;
    logic [15:0] wr1_val;
    logic        mem_we_d;
    logic        fault_d;

    function automatic logic top_bit(input logic [15:0] v, input logic bm);
        top_bit = bm ? v[7] : v[15];
    endfunction

    // Unsigned operands get a zero 17th bit, signed ones their sign
    function automatic logic [16:0] ext17(input logic [15:0] v, input logic sgn);
        ext17 = {sgn & v[15], v};
    endfunction

    function automatic logic is_zero(input logic [15:0] v, input logic bm);
        is_zero = bm ? (v[7:0] == 8'h00) : (v == 16'h0000);
    endfunction

    // Classic single cycle: answer one cycle after the strobe, write on the ack edge
    assign bus_req  = wb_cyc_i & wb_stb_i;
    assign bus_wr   = bus_req & wb_we_i & ack_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q  <= bus_req & ~ack_q;
            rdat_q <= 32'h0000_0000;
            if (wb_adr_i[`CAC_WREG_BIT])
                rdat_q[15:0] <= wreg_q[wb_adr_i[5:2]];
            else if (wb_adr_i == `CAC_OFF_CTRL)
                rdat_q[3:2] <= {iplx_q, view_q};
            else if (wb_adr_i == `CAC_OFF_TPAG)
                rdat_q[7:0] <= tpag_q;
            else if (wb_adr_i == `CAC_OFF_VPAG)
                rdat_q[7:0] <= vpag_q;
            else if (wb_adr_i == `CAC_OFF_HOLD)
                rdat_q[13:0] <= hold_q;
            else if (wb_adr_i == `CAC_OFF_STAT)
                rdat_q[15:0] <= stat_q;
        end
    end

    // Operand fetch
    always_comb
    begin
        if (exec_kind_i == CAC_K_MUL && mul_mode_i == CAC_M_LEG)
        begin
            // Legacy form always takes its second operand from data space
            opa = wreg_q[`CAC_LEG_LO];
            opb = mem_data_i;
        end
        else
        begin
            opa = wreg_q[wa_i];
            opb = src_mem_i ? mem_data_i : wreg_q[wb_i];
        end
        mem_rd_addr_o = {3'b000, legacy_addr_i};
    end

    // ALU and flag generation
    always_comb
    begin
        is_sub = (alu_op_i == CAC_SUB) || (alu_op_i == CAC_SUBB);
        if (alu_op_i == CAC_ADDC || alu_op_i == CAC_SUBB)
            cin = stat_q[`CAC_BIT_C];
        else
            cin = is_sub;
        bx = is_sub ? ~opb : opb;
        sum = {1'b0, opa} + {1'b0, bx} + {16'h0000, cin};
        alu_stat = stat_q;
        alu_res = sum[15:0];
        case (alu_op_i)
            CAC_ADD, CAC_ADDC, CAC_SUB, CAC_SUBB:
            begin
                // C set means no borrow on subtract, likewise DC
                alu_stat[`CAC_BIT_C] = byte_mode_i ? (opa[8] ^ bx[8] ^ sum[8])
                                                   : sum[16];
                alu_stat[`CAC_BIT_DC] = byte_mode_i ? (opa[4] ^ bx[4] ^ sum[4])
                                                    : (opa[8] ^ bx[8] ^ sum[8]);
                alu_stat[`CAC_BIT_OV] = (top_bit(opa, byte_mode_i) == top_bit(bx, byte_mode_i))
                                      && (top_bit(sum[15:0], byte_mode_i)
                                          != top_bit(opa, byte_mode_i));
            end
            CAC_AND: alu_res = opa & opb;
            CAC_IOR: alu_res = opa | opb;
            CAC_XOR: alu_res = opa ^ opb;
            CAC_SL:
            begin
                alu_res = {opa[14:0], 1'b0};
                alu_stat[`CAC_BIT_C] = top_bit(opa, byte_mode_i);
            end
            CAC_LSR, CAC_ASR:
            begin
                alu_res = {1'b0, opa[15:1]};
                if (byte_mode_i)
                    alu_res[7] = (alu_op_i == CAC_ASR) & opa[7];
                else
                    alu_res[15] = (alu_op_i == CAC_ASR) & opa[15];
                alu_stat[`CAC_BIT_C] = opa[0];
            end
            default: alu_res = sum[15:0];
        endcase
        alu_stat[`CAC_BIT_Z] = is_zero(alu_res, byte_mode_i);
        alu_stat[`CAC_BIT_N] = top_bit(alu_res, byte_mode_i);
        alu_upd = exec_valid_i && exec_kind_i == CAC_K_ALU;
    end

    // Multiplier: one signed 17x17 product serves every mode
    always_comb
    begin
        mul_a = ext17(opa, 1'b0);
        mul_b = ext17(opb, 1'b0);
        case (mul_mode_i)
            CAC_M_SS:
            begin
                mul_a = ext17(opa, 1'b1);
                mul_b = ext17(opb, 1'b1);
            end
            CAC_M_SLIT:
            begin
                mul_a = ext17(opa, 1'b1);
                mul_b = {12'h000, lit5_i};
            end
            CAC_M_ULIT: mul_b = {12'h000, lit5_i};
            CAC_M_US:   mul_b = ext17(opb, 1'b1);
            CAC_M_LEG:
            begin
                if (byte_mode_i)
                begin
                    mul_a = {9'h000, opa[7:0]};
                    mul_b = {9'h000, opb[7:0]};
                end
            end
            CAC_M_BYTE:
            begin
                mul_a = {9'h000, opa[7:0]};
                mul_b = {9'h000, opb[7:0]};
            end
            default: mul_a = ext17(opa, 1'b0);
        endcase
        prod = $signed(mul_a) * $signed(mul_b);
        mul_res = prod[31:0];
    end

    // Divider, single pass; a zero divisor is replaced so no X reaches the quotient
    always_comb
    begin
        if (div_long_i)
            dvd = {wreg_q[{wa_i[3:1], 1'b1}], wreg_q[{wa_i[3:1], 1'b0}]};
        else
            dvd = {{16{div_signed_i & opa[15]}}, opa};
        if (opb == 16'h0000)
            dvs = 32'h0000_0001;
        else
            dvs = {{16{div_signed_i & opb[15]}}, opb};
        if (div_signed_i)
        begin
            quo = 32'($signed(dvd) / $signed(dvs));
            rem = 32'($signed(dvd) % $signed(dvs));
        end
        else
        begin
            quo = dvd / dvs;
            rem = dvd % dvs;
        end
    end

    // Write-back steering
    always_comb
    begin
        wr0_en   = 1'b0;
        wr0_idx  = wd_i;
        wr0_val  = alu_res;
        wr0_byte = byte_mode_i;
        wr1_en   = 1'b0;
        wr1_idx  = {wd_i[3:1], 1'b1};
        wr1_val  = mul_res[31:16];
        mem_we_d = 1'b0;
        fault_d  = 1'b0;
        if (exec_valid_i)
        begin
            case (exec_kind_i)
                CAC_K_ALU:
                begin
                    mem_we_d = dest_mem_i;
                    wr0_en   = ~dest_mem_i;
                end
                CAC_K_MUL:
                begin
                    wr0_val  = mul_res[15:0];
                    wr0_byte = 1'b0;
                    if (mul_mode_i == CAC_M_LEG)
                    begin
                        // Byte form leaves the high register alone
                        wr0_en  = 1'b1;
                        wr0_idx = `CAC_LEG_LO;
                        wr1_en  = ~byte_mode_i;
                        wr1_idx = `CAC_LEG_HI;
                    end
                    else if (wd_i[3:1] == `CAC_TOP_PAIR)
                        fault_d = 1'b1;
                    else
                    begin
                        wr0_en  = 1'b1;
                        wr0_idx = {wd_i[3:1], 1'b0};
                        wr1_en  = 1'b1;
                    end
                end
                CAC_K_DIV:
                begin
                    wr0_byte = 1'b0;
                    if (opb == 16'h0000)
                        fault_d = 1'b1;
                    else
                    begin
                        wr0_en  = 1'b1;
                        wr0_idx = `CAC_Q_REG;
                        wr0_val = quo[15:0];
                        wr1_en  = 1'b1;
                        wr1_idx = `CAC_R_REG;
                        wr1_val = rem[15:0];
                    end
                end
                default: wr0_en = 1'b0;
            endcase
        end
    end

    // Working registers; in byte mode ALU results write only the low byte, bus, multiply and divide writes reach the high byte
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 16; i++)
                wreg_q[i] <= `CAC_RST_WREG;
        end
        else
        begin
            if (bus_wr && wb_adr_i[`CAC_WREG_BIT])
            begin
                if (wb_sel_i[0])
                    wreg_q[wb_adr_i[5:2]][7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    wreg_q[wb_adr_i[5:2]][15:8] <= wb_dat_i[15:8];
            end
            if (wr0_en)
            begin
                wreg_q[wr0_idx][7:0] <= wr0_val[7:0];
                if (!wr0_byte)
                    wreg_q[wr0_idx][15:8] <= wr0_val[15:8];
            end
            if (wr1_en)
                wreg_q[wr1_idx] <= wr1_val;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mem_we_q    <= 1'b0;
            mem_wdata_q <= 16'h0000;
            mem_byte_q  <= 1'b0;
            fault_q     <= 1'b0;
        end
        else
        begin
            mem_we_q   <= mem_we_d;
            mem_byte_q <= mem_we_d & byte_mode_i;
            fault_q    <= fault_d;
            if (mem_we_d)
                mem_wdata_q <= alu_res;
        end
    end

    // Status word: an ALU update in the same cycle beats a bus write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            stat_q <= `CAC_RST_STAT;
        else if (alu_upd)
            stat_q <= alu_stat;
        else if (bus_wr && wb_adr_i == `CAC_OFF_STAT)
        begin
            if (wb_sel_i[0])
                stat_q[7:0] <= wb_dat_i[7:0] & 8'(`CAC_STAT_WMASK);
            if (wb_sel_i[1])
                stat_q[15:8] <= wb_dat_i[15:8] & 8'(`CAC_STAT_WMASK >> 8);
        end
    end

    // Extension bit: hardware sets, software may only clear; set wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            iplx_q <= 1'(`CAC_RST_CTRL >> `CAC_BIT_IPLX);
        else if (ipl_ext_set_i)
            iplx_q <= 1'b1;
        else if (bus_wr && wb_adr_i == `CAC_OFF_CTRL && wb_sel_i[0] && !wb_dat_i[`CAC_BIT_IPLX])
            iplx_q <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            view_q <= 1'(`CAC_RST_CTRL >> `CAC_BIT_VIEW);
            tpag_q <= `CAC_RST_PAGE;
            vpag_q <= `CAC_RST_PAGE;
        end
        else if (bus_wr && wb_sel_i[0])
        begin
            if (wb_adr_i == `CAC_OFF_CTRL)
                view_q <= wb_dat_i[`CAC_BIT_VIEW];
            else if (wb_adr_i == `CAC_OFF_TPAG)
                tpag_q <= wb_dat_i[7:0];
            else if (wb_adr_i == `CAC_OFF_VPAG)
                vpag_q <= wb_dat_i[7:0];
        end
    end

    // Hold counter counts down once per cycle; an instruction load beats a bus write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            hold_q <= `CAC_RST_HOLD;
        else if (hold_start_i)
            hold_q <= hold_count_i;
        else if (bus_wr && wb_adr_i == `CAC_OFF_HOLD && wb_sel_i[1:0] == 2'b11)
            hold_q <= wb_dat_i[13:0];
        else if (hold_q != 14'h0000)
            hold_q <= hold_q - 14'h0001;
    end

    assign mem_wdata_o      = mem_wdata_q;
    assign mem_we_o         = mem_we_q;
    assign mem_byte_o       = mem_byte_q;
    assign exec_fault_o     = fault_q;
    assign status_o         = stat_q;
    assign ipl_o            = {iplx_q, stat_q[`CAC_BIT_IPL+2:`CAC_BIT_IPL]};
    assign user_irq_block_o = iplx_q;
    assign low_irq_hold_o   = hold_q != 14'h0000;
    assign tbl_addr_o       = {tpag_q, tbl_ea_i};
    // Upper half of data space maps onto the selected program region
    assign view_hit_o       = view_q & data_addr_i[15];
    assign view_addr_o      = {vpag_q, data_addr_i[14:0]};

endmodule

// [test/cac_core_props.sv]
// Port-level assertions on the core datapath, bound into cac_core
`timescale 1ns/1ps
module cac_core_props (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic [31:0]            wb_dat_o,
    input wire logic                   wb_ack_o,
    input wire logic                   exec_valid_i,
    input wire cac_pkg::cac_kind_t     exec_kind_i,
    input wire cac_pkg::cac_mul_mode_t mul_mode_i,
    input wire logic [3:0]             wd_i,
    input wire logic                   exec_fault_o,
    input wire logic                   ipl_ext_set_i,
    input wire logic                   hold_start_i,
    input wire logic [13:0]            hold_count_i,
    input wire logic [3:0]             ipl_o,
    input wire logic                   user_irq_block_o,
    input wire logic                   low_irq_hold_o,
    input wire logic [15:0]            status_o
);
    import cac_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack late");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held");
    a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read data set");
    a_block_ext_bit: assert property (user_irq_block_o == ipl_o[3])
        else $error("block differs from level bit 3");
    a_level_low_bits: assert property (ipl_o[2:0] == status_o[7:5])
        else $error("level low bits differ from status");
    a_ext_set_pulse: assert property (ipl_ext_set_i |=> user_irq_block_o)
        else $error("extension bit not set");
    a_ext_clear_only: assert property (
        !user_irq_block_o && !ipl_ext_set_i |=> !user_irq_block_o)
        else $error("extension bit set without request");
    a_hold_loaded: assert property (
        hold_start_i && hold_count_i != 14'h0000 |=> low_irq_hold_o)
        else $error("hold not active after load");
    a_top_pair_fault: assert property (
        exec_valid_i && exec_kind_i == CAC_K_MUL && mul_mode_i != CAC_M_LEG
        && wd_i[3:1] == 3'h7 |=> exec_fault_o)
        else $error("top pair multiply not refused");

    c_bus_ack: cover property (wb_ack_o);
    c_fault: cover property (exec_fault_o);
    c_hold_end: cover property ($fell(low_irq_hold_o));
endmodule

bind cac_core cac_core_props u_props (.*);

// [test/tb_top.sv]
// Self-checking bench of the core datapath: bus, control, ALU and multiplier
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            errors++; \
            $display("mismatch %s exp %h got %h", nm, e, g); \
        end \
    end
module tb_top;
    import cac_pkg::*;
    logic          clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, exec_valid_i;
    logic          byte_mode_i, src_mem_i, dest_mem_i, div_signed_i, div_long_i;
    logic          mem_we_o, mem_byte_o, exec_fault_o, ipl_ext_set_i, hold_start_i;
    logic          user_irq_block_o, low_irq_hold_o, view_hit_o;
    logic [3:0]    wb_sel_i, wa_i, wb_i, wd_i, ipl_o;
    logic [4:0]    lit5_i;
    logic [6:0]    wb_adr_i;
    logic [12:0]   legacy_addr_i;
    logic [13:0]   hold_count_i;
    logic [15:0]   mem_data_i, mem_rd_addr_o, mem_wdata_o, tbl_ea_i, data_addr_i, status_o;
    logic [22:0]   view_addr_o;
    logic [23:0]   tbl_addr_o;
    logic [31:0]   wb_dat_i, wb_dat_o;
    cac_kind_t     exec_kind_i;
    cac_alu_op_t   alu_op_i;
    cac_mul_mode_t mul_mode_i;
    int            errors, n_tests;

    cac_core dut (.*);

    always #2 clk_i = ~clk_i;

    // Values read right after an edge are those launched by the edge before
    task automatic bus(input logic w, input logic [6:0] a, input logic [15:0] d,
                       input logic [3:0] s, output logic [15:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        wb_sel_i <= s;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic [3:0] s);
        logic [15:0] q;
        bus(1'b1, a, d, s, q);
    endtask

    task automatic rd_chk(input string nm, input logic [6:0] a, input logic [15:0] e);
        logic [15:0] q;
        bus(1'b0, a, 16'h0000, 4'h3, q);
        `CHK(nm, e, q)
    endtask

    task automatic ex(input cac_kind_t k, input cac_alu_op_t op, input cac_mul_mode_t m,
                      input logic [3:0] a, input logic [3:0] b, input logic [3:0] d);
        @(posedge clk_i);
        exec_valid_i <= 1'b1;
        exec_kind_i <= k;
        alu_op_i <= op;
        mul_mode_i <= m;
        wa_i <= a;
        wb_i <= b;
        wd_i <= d;
        @(posedge clk_i);
        exec_valid_i <= 1'b0;
    endtask

    task automatic t_regs();
        rd_chk("ctrl", 7'h00, 16'h0000);
        rd_chk("unmapped", 7'h3c, 16'h0000);
        wr(7'h00, 16'hffff, 4'h3);
        rd_chk("ctrl", 7'h00, 16'h0004);
        ipl_ext_set_i <= 1'b1;
        @(posedge clk_i);
        ipl_ext_set_i <= 1'b0;
        @(posedge clk_i);
        `CHK("block", 1'b1, user_irq_block_o)
        `CHK("ipl", 4'h8, ipl_o)
        rd_chk("ctrl", 7'h00, 16'h000c);
        wr(7'h00, 16'h0004, 4'h3);
        rd_chk("ctrl", 7'h00, 16'h0004);
        wr(7'h08, 16'h005a, 4'h1);
        wr(7'h04, 16'h00a5, 4'h1);
        data_addr_i <= 16'h8123;
        tbl_ea_i <= 16'h1234;
        @(posedge clk_i);
        `CHK("view hit", 1'b1, view_hit_o)
        `CHK("view addr", {8'h5a, 15'h0123}, view_addr_o)
        `CHK("tbl addr", 24'ha51234, tbl_addr_o)
        wr(7'h00, 16'h0000, 4'h3);
        @(posedge clk_i);
        `CHK("view off", 1'b0, view_hit_o)
    endtask

    task automatic t_hold();
        hold_count_i <= 14'h0003;
        hold_start_i <= 1'b1;
        @(posedge clk_i);
        hold_start_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK("hold last", 1'b1, low_irq_hold_o)
        @(posedge clk_i);
        `CHK("hold over", 1'b0, low_irq_hold_o)
    endtask

    task automatic t_alu();
        wr(7'h44, 16'h7fff, 4'h3);
        wr(7'h48, 16'h0001, 4'h3);
        ex(CAC_K_ALU, CAC_ADD, CAC_M_SS, 4'h1, 4'h2, 4'h3);
        rd_chk("w3", 7'h4c, 16'h8000);
        rd_chk("sr", 7'h10, 16'h010c);
        wr(7'h50, 16'hab80, 4'h3);
        mem_data_i <= 16'h0080;
        src_mem_i <= 1'b1;
        byte_mode_i <= 1'b1;
        ex(CAC_K_ALU, CAC_ADD, CAC_M_SS, 4'h4, 4'h0, 4'h4);
        rd_chk("w4", 7'h50, 16'hab00);
        rd_chk("sr", 7'h10, 16'h0007);
        mem_data_i <= 16'h0001;
        byte_mode_i <= 1'b0;
        ex(CAC_K_ALU, CAC_SUB, CAC_M_SS, 4'h1, 4'h0, 4'h5);
        rd_chk("w5", 7'h54, 16'h7ffe);
        rd_chk("sr", 7'h10, 16'h0101);
    endtask

    task automatic t_mul();
        cac_mul_mode_t md[6] = '{CAC_M_SS, CAC_M_UU, CAC_M_SLIT, CAC_M_ULIT, CAC_M_US,
                                 CAC_M_BYTE};
        logic [31:0] pr[6] = '{32'h00000001, 32'hfffe0001, 32'hffffffe1, 32'h001effe1,
                               32'hffff0001, 32'h0000fe01};
        wr(7'h44, 16'hffff, 4'h3);
        mem_data_i <= 16'hffff;
        lit5_i <= 5'h1f;
        for (int i = 0; i < 6; i++)
        begin
            ex(CAC_K_MUL, CAC_ADD, md[i], 4'h1, 4'h0, 4'h4);
            rd_chk("hi", 7'h54, pr[i][31:16]);
            rd_chk("lo", 7'h50, pr[i][15:0]);
        end
        ex(CAC_K_MUL, CAC_ADD, CAC_M_SS, 4'h1, 4'h0, 4'he);
        @(posedge clk_i);
        `CHK("fault", 1'b1, exec_fault_o)
        rd_chk("w14", 7'h78, 16'h0000);
    endtask

    task automatic t_legacy();
        wr(7'h48, 16'h0003, 4'h3);
        wr(7'h4c, 16'h1234, 4'h3);
        legacy_addr_i <= 13'h1abc;
        src_mem_i <= 1'b0;
        mem_data_i <= 16'h00ff;
        byte_mode_i <= 1'b1;
        ex(CAC_K_MUL, CAC_ADD, CAC_M_LEG, 4'h0, 4'h0, 4'h0);
        `CHK("leg addr", 16'h1abc, mem_rd_addr_o)
        rd_chk("w2", 7'h48, 16'h02fd);
        rd_chk("w3", 7'h4c, 16'h1234);
        mem_data_i <= 16'h0002;
        byte_mode_i <= 1'b0;
        ex(CAC_K_MUL, CAC_ADD, CAC_M_LEG, 4'h0, 4'h0, 4'h0);
        rd_chk("w2", 7'h48, 16'h05fa);
        rd_chk("w3", 7'h4c, 16'h0000);
    endtask

    task automatic t_misc();
        wr(7'h58, 16'h1284, 4'h3);
        wr(7'h54, 16'h0001, 4'h3);
        {src_mem_i, dest_mem_i, byte_mode_i} <= 3'b011;
        ex(CAC_K_ALU, CAC_ASR, CAC_M_SS, 4'h6, 4'h6, 4'h6);
        {dest_mem_i, byte_mode_i} <= 2'b00;
        @(posedge clk_i);
        `CHK("mem we", 2'b11, {mem_we_o, mem_byte_o})
        `CHK("mem data", 8'hc2, mem_wdata_o[7:0])
        @(posedge clk_i);
        `CHK("mem we end", 1'b0, mem_we_o)
        rd_chk("w6", 7'h58, 16'h1284);
        rd_chk("sr", 7'h10, 16'h0108);
        ex(CAC_K_ALU, CAC_SUBB, CAC_M_SS, 4'h6, 4'h6, 4'h9);
        rd_chk("w9", 7'h64, 16'hffff);
        `CHK("status", 16'h0008, status_o)
        {src_mem_i, div_signed_i} <= 2'b11;
        mem_data_i <= 16'hfff0;
        ex(CAC_K_DIV, CAC_ADD, CAC_M_SS, 4'h6, 4'h0, 4'h0);
        rd_chk("quo", 7'h40, 16'hfed8);
        rd_chk("rem", 7'h44, 16'h0004);
        {div_signed_i, div_long_i} <= 2'b01;
        mem_data_i <= 16'h0010;
        ex(CAC_K_DIV, CAC_ADD, CAC_M_SS, 4'h4, 4'h0, 4'h0);
        rd_chk("quo long", 7'h40, 16'h1fe0);
        rd_chk("rem long", 7'h44, 16'h0001);
        mem_data_i <= 16'h0000;
        ex(CAC_K_DIV, CAC_ADD, CAC_M_SS, 4'h4, 4'h0, 4'h0);
        @(posedge clk_i);
        `CHK("div zero", 1'b1, exec_fault_o)
        rd_chk("quo kept", 7'h40, 16'h1fe0);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, exec_valid_i, byte_mode_i, src_mem_i} = '0;
        {dest_mem_i, div_signed_i, div_long_i, ipl_ext_set_i, hold_start_i} = '0;
        {wb_sel_i, wa_i, wb_i, wd_i, lit5_i, wb_adr_i, legacy_addr_i, hold_count_i} = '0;
        {mem_data_i, tbl_ea_i, data_addr_i, wb_dat_i} = '0;
        exec_kind_i = CAC_K_NONE;
        alu_op_i = CAC_ADD;
        mul_mode_i = CAC_M_SS;
        errors = 0;
        n_tests = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_hold();
        t_alu();
        t_mul();
        t_legacy();
        t_misc();
        tally_and_finish();
    end

    // The tests need a few hundred cycles; 5000 leaves a wide margin
    initial
    begin
        #20000;
        errors++;
        tally_and_finish();
    end
endmodule
